// ===== key_irq_cfg.svh
// Offsets, field positions, reset values and counts of the keyboard block.
`ifndef KEY_IRQ_CFG_SVH
`define KEY_IRQ_CFG_SVH
`define KEY_LINES              8
`define KEY_LEVEL_SELECT_IDX   8'h9C
`define KEY_LINE_ENABLE_IDX    8'h9D
`define KEY_LINE_FLAG_IDX      8'h9E
`define KEY_IRQ_ENABLE2_IDX    8'hB1
`define KEY_IRQ_STATUS_IDX     8'hC0
`define KEY_IRQ_CLEAR_IDX      8'hC1
`define KEY_IRQ_EVENT_EN_IDX   8'hC2
`define KEY_INFO_IDX           8'hC3
`define KEY_GLOBAL_EN_BIT      0
`define KEY_EV_REQUEST_BIT     0
`define KEY_EV_WAKE_BIT        1
`define KEY_EVENTS             2
`define KEY_RESET_8            8'h00
`define KEY_SOURCE_NUMBER      8'h08
`define KEY_POLL_PRIORITY      8'h08
`define KEY_VECTOR_ADDR        16'h003B
`define KEY_RESP_OKAY          2'b00
`define KEY_RESP_DECERR        2'b11
`endif

// ===== key_irq_pkg.sv
// Types shared by the keyboard interrupt block.
package key_irq_pkg;
   typedef enum logic [1:0] {
      WR_IDLE,
      WR_RESP
   } wr_state_e;
   typedef logic [7:0] line_vec_t;
endpackage

// ===== key_line_detect.sv
// Per-line level compare and sticky flag for the keyboard lines.
`timescale 1ns/1ps
`include "key_irq_cfg.svh"
module key_line_detect #(
   parameter int LINES = `KEY_LINES
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [LINES-1:0] scan_input_port,
   input  wire logic [LINES-1:0] key_level_select,
   input  wire logic [LINES-1:0] flag_clear,
   output logic      [LINES-1:0] key_line_flags,
   output logic      [LINES-1:0] level_hit
);
   logic [LINES-1:0] flag_reg;
   logic [LINES-1:0] flag_next;

   // A select bit of one matches a high pin, zero matches a low pin.
   assign level_hit = ~(scan_input_port ^ key_level_select);
   // Set wins over a clear that lands in the same cycle.
   assign flag_next = (flag_reg & ~flag_clear) | level_hit;
   assign key_line_flags = flag_reg;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   property p_flag_sets;
      @(posedge clock) disable iff (!reset_n)
         level_hit[0] |=> key_line_flags[0];
   endproperty
   a_flag_sets: assert property (p_flag_sets)
      else $error("Line flag did not set on its level.");

   property p_flag_holds;
      @(posedge clock) disable iff (!reset_n)
         (key_line_flags[1] && !flag_clear[1]) |=> key_line_flags[1];
   endproperty
   a_flag_holds: assert property (p_flag_holds)
      else $error("Line flag dropped without a clear.");
endmodule

// ===== keyboard_level_interrupt.sv
// Keyboard level interrupt block with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "key_irq_cfg.svh"
module keyboard_level_interrupt #(
   parameter int LINES = `KEY_LINES
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [LINES-1:0] scan_input_port,
   output logic      [LINES-1:0] key_line_active,
   output logic                  keyboard_irq_request,
   output logic                  wake_request,
   output logic                  irq,
   input  wire logic [31:0]      s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [31:0]      s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready
);
   logic [LINES-1:0] key_level_select_reg;
   logic [LINES-1:0] key_line_enables_reg;
   logic             global_enable_reg;
   logic [`KEY_EVENTS-1:0] status_reg;
   logic [`KEY_EVENTS-1:0] status_next;
   logic [`KEY_EVENTS-1:0] event_en_reg;
   logic [LINES-1:0] key_line_flags;
   logic [LINES-1:0] level_hit;
   logic [LINES-1:0] flag_clear;
   logic [LINES-1:0] key_line_mask;
   logic [`KEY_EVENTS-1:0] events;
   logic [`KEY_EVENTS-1:0] status_clear;
   logic             request_prev_reg;
   logic             wake_prev_reg;

   logic [31:0]      awaddr_reg;
   logic [31:0]      wdata_reg;
   logic [3:0]       wstrb_reg;
   logic             aw_held_reg;
   logic             w_held_reg;
   key_irq_pkg::wr_state_e wr_state_reg;
   logic [1:0]       bresp_reg;
   logic             rvalid_reg;
   logic [31:0]      rdata_reg;
   logic [1:0]       rresp_reg;

   // Byte address is four times the printed register index.
   function automatic logic [31:0] byte_addr(input logic [7:0] idx);
      byte_addr = {22'h000000, idx, 2'b00};
   endfunction

   function automatic logic hits(input logic [31:0] a, input logic [7:0] idx);
      hits = (a == byte_addr(idx));
   endfunction

   key_line_detect #(
      .LINES (LINES)
   ) u_detect (
      .clock            (clock),
      .reset_n          (reset_n),
      .scan_input_port  (scan_input_port),
      .key_level_select (key_level_select_reg),
      .flag_clear       (flag_clear),
      .key_line_flags   (key_line_flags),
      .level_hit        (level_hit)
   );

   // Per-line request terms; disabled lines contribute nothing.
   assign key_line_mask = key_line_flags
                        & key_line_enables_reg;
   // One shared request for all lines, so software polls the flags.
   assign keyboard_irq_request = global_enable_reg
                               & (|key_line_mask);
   // Wake is combinational so it still works while the clock is gated.
   assign wake_request = |(level_hit & key_line_enables_reg);
   // Unused lines stay ordinary port pins for other functions.
   assign key_line_active = key_line_enables_reg;

   assign events[`KEY_EV_REQUEST_BIT] = keyboard_irq_request
                                       & ~request_prev_reg;
   assign events[`KEY_EV_WAKE_BIT] = wake_request & ~wake_prev_reg;
   assign status_next = (status_reg & ~status_clear) | events;
   assign irq = |(status_reg & event_en_reg);

   // Write path: address and data are held independently, then applied.
   wire aw_go = aw_held_reg && w_held_reg
              && (wr_state_reg == key_irq_pkg::WR_IDLE);
   wire wr_lo = wstrb_reg[0];
   wire wr_ls = aw_go && wr_lo && hits(awaddr_reg, `KEY_LEVEL_SELECT_IDX);
   wire wr_le = aw_go && wr_lo && hits(awaddr_reg, `KEY_LINE_ENABLE_IDX);
   wire wr_fl = aw_go && wr_lo && hits(awaddr_reg, `KEY_LINE_FLAG_IDX);
   wire wr_ie = aw_go && wr_lo && hits(awaddr_reg, `KEY_IRQ_ENABLE2_IDX);
   wire wr_sc = aw_go && wr_lo && hits(awaddr_reg, `KEY_IRQ_CLEAR_IDX);
   wire wr_ee = aw_go && wr_lo && hits(awaddr_reg, `KEY_IRQ_EVENT_EN_IDX);
   wire wr_ok = hits(awaddr_reg, `KEY_LEVEL_SELECT_IDX)
              | hits(awaddr_reg, `KEY_LINE_ENABLE_IDX)
              | hits(awaddr_reg, `KEY_LINE_FLAG_IDX)
              | hits(awaddr_reg, `KEY_IRQ_ENABLE2_IDX)
              | hits(awaddr_reg, `KEY_IRQ_STATUS_IDX)
              | hits(awaddr_reg, `KEY_IRQ_CLEAR_IDX)
              | hits(awaddr_reg, `KEY_IRQ_EVENT_EN_IDX)
              | hits(awaddr_reg, `KEY_INFO_IDX);

   // Flags clear by writing zero to a bit; writing one leaves it alone.
   assign flag_clear = wr_fl ? ~wdata_reg[LINES-1:0] : '0;
   assign status_clear = wr_sc ? wdata_reg[`KEY_EVENTS-1:0] : '0;

   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready = !w_held_reg;
   assign s_axi_bvalid = (wr_state_reg == key_irq_pkg::WR_RESP);
   assign s_axi_bresp = bresp_reg;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (aw_go) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end else if (aw_go) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wr_state_reg <= key_irq_pkg::WR_IDLE;
         bresp_reg <= `KEY_RESP_OKAY;
      end else begin
         case (wr_state_reg)
            key_irq_pkg::WR_IDLE: begin
               if (aw_go) begin
                  wr_state_reg <= key_irq_pkg::WR_RESP;
                  bresp_reg <= wr_ok ? `KEY_RESP_OKAY : `KEY_RESP_DECERR;
               end
            end
            key_irq_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_reg <= key_irq_pkg::WR_IDLE;
               end
            end
            default: begin
               wr_state_reg <= key_irq_pkg::WR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         key_level_select_reg <= `KEY_RESET_8;
         key_line_enables_reg <= `KEY_RESET_8;
         global_enable_reg <= 1'b0;
         event_en_reg <= '0;
         status_reg <= '0;
         request_prev_reg <= 1'b0;
         wake_prev_reg <= 1'b0;
      end else begin
         if (wr_ls) key_level_select_reg <= wdata_reg[LINES-1:0];
         if (wr_le) key_line_enables_reg <= wdata_reg[LINES-1:0];
         if (wr_ie) begin
            global_enable_reg <= wdata_reg[`KEY_GLOBAL_EN_BIT];
         end
         if (wr_ee) event_en_reg <= wdata_reg[`KEY_EVENTS-1:0];
         status_reg <= status_next;
         request_prev_reg <= keyboard_irq_request;
         wake_prev_reg <= wake_request;
      end
   end

   // Read path: one-cycle answer, held until the master takes it.
   wire [7:0] info_byte = `KEY_SOURCE_NUMBER;
   wire [31:0] rd_mux =
      hits(s_axi_araddr, `KEY_LEVEL_SELECT_IDX) ? 32'(key_level_select_reg) :
      hits(s_axi_araddr, `KEY_LINE_ENABLE_IDX)  ? 32'(key_line_enables_reg) :
      hits(s_axi_araddr, `KEY_LINE_FLAG_IDX)    ? 32'(key_line_flags) :
      hits(s_axi_araddr, `KEY_IRQ_ENABLE2_IDX)  ? 32'(global_enable_reg) :
      hits(s_axi_araddr, `KEY_IRQ_STATUS_IDX)   ? 32'(status_reg) :
      hits(s_axi_araddr, `KEY_IRQ_EVENT_EN_IDX) ? 32'(event_en_reg) :
      hits(s_axi_araddr, `KEY_INFO_IDX)
         ? {`KEY_VECTOR_ADDR, `KEY_POLL_PRIORITY, info_byte} : 32'h00000000;
   wire rd_ok = hits(s_axi_araddr, `KEY_LEVEL_SELECT_IDX)
              | hits(s_axi_araddr, `KEY_LINE_ENABLE_IDX)
              | hits(s_axi_araddr, `KEY_LINE_FLAG_IDX)
              | hits(s_axi_araddr, `KEY_IRQ_ENABLE2_IDX)
              | hits(s_axi_araddr, `KEY_IRQ_STATUS_IDX)
              | hits(s_axi_araddr, `KEY_IRQ_CLEAR_IDX)
              | hits(s_axi_araddr, `KEY_IRQ_EVENT_EN_IDX)
              | hits(s_axi_araddr, `KEY_INFO_IDX);

   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= `KEY_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_mux;
         rresp_reg <= rd_ok ? `KEY_RESP_OKAY : `KEY_RESP_DECERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   sequence s_line_armed;
      key_line_flags[0] && key_line_enables_reg[0];
   endsequence

   property p_request_on_armed;
      @(posedge clock) disable iff (!reset_n)
         (s_line_armed and global_enable_reg) |-> keyboard_irq_request;
   endproperty
   a_request_on_armed: assert property (p_request_on_armed)
      else $error("Armed line gave no request.");

   property p_global_gate;
      @(posedge clock) disable iff (!reset_n)
         !global_enable_reg |-> !keyboard_irq_request;
   endproperty
   a_global_gate: assert property (p_global_gate)
      else $error("Request passed with global enable low.");

   property p_no_unarmed_request;
      @(posedge clock) disable iff (!reset_n)
         (key_line_mask == '0) |-> !keyboard_irq_request;
   endproperty
   a_no_unarmed_request: assert property (p_no_unarmed_request)
      else $error("Request with no armed line.");

   property p_level_to_flag;
      @(posedge clock) disable iff (!reset_n)
         (scan_input_port[2] == key_level_select_reg[2]) |=> key_line_flags[2];
   endproperty
   a_level_to_flag: assert property (p_level_to_flag)
      else $error("Selected level did not set the flag.");

   property p_disabled_silent;
      @(posedge clock) disable iff (!reset_n)
         (key_line_enables_reg == '0)
            |-> !wake_request && !keyboard_irq_request;
   endproperty
   a_disabled_silent: assert property (p_disabled_silent)
      else $error("Disabled lines raised a request.");

   property p_wake;
      @(posedge clock) disable iff (!reset_n)
         (key_line_enables_reg[3] && level_hit[3]) |-> wake_request;
   endproperty
   a_wake: assert property (p_wake)
      else $error("Enabled level gave no wake.");

   property p_read_answer;
      @(posedge clock) disable iff (!reset_n)
         (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("Read got no answer next cycle.");

   property p_flag_sticky;
      @(posedge clock) disable iff (!reset_n)
         (key_line_flags[4] && !flag_clear[4]) |=> key_line_flags[4] [*1];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("Flag cleared by hardware.");

   property p_all_hits_set;
      @(posedge clock) disable iff (!reset_n)
         (level_hit != '0)
            |=> ((key_line_flags & $past(level_hit)) == $past(level_hit));
   endproperty
   a_all_hits_set: assert property (p_all_hits_set)
      else $error("A line level did not set its flag.");

   property p_no_hw_clear;
      @(posedge clock) disable iff (!reset_n)
         1'b1 |=> ((~key_line_flags
                    & $past(key_line_flags & ~flag_clear)) == '0);
   endproperty
   a_no_hw_clear: assert property (p_no_hw_clear)
      else $error("A flag fell without a software clear.");

   property p_wake_needs_enable;
      @(posedge clock) disable iff (!reset_n)
         wake_request |-> ((level_hit & key_line_enables_reg) != '0);
   endproperty
   a_wake_needs_enable: assert property (p_wake_needs_enable)
      else $error("Wake raised by a line that is not enabled.");

   property p_select_write;
      @(posedge clock) disable iff (!reset_n)
         wr_ls |=> (key_level_select_reg == $past(wdata_reg[LINES-1:0]));
   endproperty
   a_select_write: assert property (p_select_write)
      else $error("Level select write did not land.");

   property p_enable_write;
      @(posedge clock) disable iff (!reset_n)
         wr_le |=> (key_line_enables_reg == $past(wdata_reg[LINES-1:0]));
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("Line enable write did not land.");

   property p_wake_event;
      @(posedge clock) disable iff (!reset_n)
         events[`KEY_EV_WAKE_BIT] |=> status_reg[`KEY_EV_WAKE_BIT];
   endproperty
   a_wake_event: assert property (p_wake_event)
      else $error("Wake event was not latched in status.");
endmodule

// ===== key_matrix_model.sv
// Behavioural model of the matrix keyboard lines on the scan input port.
`timescale 1ns/1ps
module key_matrix_model (
   input  wire logic       clock,
   input  wire logic       slow,
   input  wire logic [7:0] keys_down,
   output logic      [7:0] scan_lines
);
   logic [7:0] late_reg;

   // A slow key closes one clock late, as a bouncing contact would.
   always_ff @(posedge clock) begin
      late_reg <= keys_down;
   end

   // Pull-ups hold released lines high; any subset of lines may be wired.
   assign scan_lines = ~(slow ? late_reg : keys_down);
endmodule

// ===== testbench.sv
// Self-checking bench for the keyboard level interrupt block.
`timescale 1ns/1ps
`include "key_irq_cfg.svh"
module testbench;
   localparam logic [7:0] LS = `KEY_LEVEL_SELECT_IDX;
   localparam logic [7:0] EN = `KEY_LINE_ENABLE_IDX;
   localparam logic [7:0] FL = `KEY_LINE_FLAG_IDX;
   localparam logic [7:0] GE = `KEY_IRQ_ENABLE2_IDX;
   localparam logic [7:0] ST = `KEY_IRQ_STATUS_IDX;
   localparam logic [7:0] CL = `KEY_IRQ_CLEAR_IDX;
   localparam logic [7:0] EE = `KEY_IRQ_EVENT_EN_IDX;
   logic        clock, reset_n, slow;
   logic [7:0]  keys_down, scan_input_port, key_line_active;
   logic        keyboard_irq_request, wake_request, irq;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] rd;
   logic [7:0]  regs [6];
   int          miscompares, checked;

   key_matrix_model u_keys (.clock, .slow, .keys_down,
      .scan_lines(scan_input_port));
   keyboard_level_interrupt u_dut (.clock, .reset_n, .scan_input_port,
      .key_line_active, .keyboard_irq_request, .wake_request, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   always #25 clock = ~clock;

   task automatic end_sim;
      if (miscompares == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
         miscompares++;
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Handshakes are judged at the falling edge, where nothing is moving.
   task automatic axi_write(input logic [7:0] idx, input logic [7:0] d,
                            output logic [1:0] resp);
      logic aw_hit, w_hit, b_hit;
      b_hit = 1'b0;
      s_axi_awaddr <= {22'h000000, idx, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 40 && b_hit !== 1'b1; n++) begin
         @(negedge clock);
         aw_hit = s_axi_awvalid & s_axi_awready;
         w_hit = s_axi_wvalid & s_axi_wready;
         b_hit = s_axi_bvalid & s_axi_bready;
         resp = s_axi_bresp;
         @(posedge clock);
         if (aw_hit === 1'b1) s_axi_awvalid <= 1'b0;
         if (w_hit === 1'b1) s_axi_wvalid <= 1'b0;
         if (b_hit === 1'b1) s_axi_bready <= 1'b0;
      end
      if (b_hit !== 1'b1) begin
         miscompares++;
         end_sim();
      end
      @(posedge clock);
   endtask

   task automatic axi_read(input logic [7:0] idx, output logic [31:0] d,
                           output logic [1:0] resp);
      logic ar_hit, r_hit;
      r_hit = 1'b0;
      s_axi_araddr <= {22'h000000, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 40 && r_hit !== 1'b1; n++) begin
         @(negedge clock);
         ar_hit = s_axi_arvalid & s_axi_arready;
         r_hit = s_axi_rvalid & s_axi_rready;
         d = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge clock);
         if (ar_hit === 1'b1) s_axi_arvalid <= 1'b0;
         if (r_hit === 1'b1) s_axi_rready <= 1'b0;
      end
      if (r_hit !== 1'b1) begin
         miscompares++;
         end_sim();
      end
      @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      axi_write(idx, d, rs);
      check("bresp", {30'h00000000, rs}, 32'h00000000);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] idx,
                         input logic [31:0] exp);
      axi_read(idx, rd, rs);
      check(name, rd, exp);
      check("rresp", {30'h00000000, rs}, 32'h00000000);
   endtask

   task automatic outs(input logic [7:0] act, input logic req,
                       input logic wk, input logic ir);
      @(negedge clock);
      check("line active", {24'h000000, key_line_active}, {24'h000000, act});
      check("request", {31'h00000000, keyboard_irq_request},
            {31'h00000000, req});
      check("wake", {31'h00000000, wake_request}, {31'h00000000, wk});
      check("irq", {31'h00000000, irq}, {31'h00000000, ir});
      @(posedge clock);
   endtask

   initial begin
      clock = 1'b0;
      reset_n = 1'b0;
      slow = 1'b0;
      keys_down = 8'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      miscompares = 0;
      checked = 0;
      regs = '{LS, EN, FL, GE, EE, ST};
      step(3);
      reset_n <= 1'b1;
      step(1);
      foreach (regs[i]) rd_chk("reset value", regs[i], 32'h00000000);
      rd_chk("info", `KEY_INFO_IDX, 32'h003B0808);
      axi_read(8'h00, rd, rs);
      check("unmapped rdata", rd, 32'h00000000);
      check("unmapped rresp", {30'h00000000, rs}, 32'h00000003);
      axi_write(8'h00, 8'hFF, rs);
      check("unmapped bresp", {30'h00000000, rs}, 32'h00000003);
      for (int i = 0; i < 8; i++) begin
         slow <= i[0];
         keys_down <= 8'h01 << i;
         step(2);
         keys_down <= 8'h00;
         step(2);
         rd_chk("line flag", FL, 32'h00000001 << i);
         wr(FL, 8'h00);
      end
      slow <= 1'b0;
      rd_chk("flags cleared", FL, 32'h00000000);
      wr(LS, 8'h0F);
      step(2);
      rd_chk("high level", FL, 32'h0000000F);
      keys_down <= 8'hF0;
      step(2);
      keys_down <= 8'h00;
      rd_chk("mixed level", FL, 32'h000000FF);
      wr(LS, 8'h00);
      wr(FL, 8'hF0);
      rd_chk("ones keep flags", FL, 32'h000000F0);
      wr(FL, 8'h00);
      keys_down <= 8'h08;
      step(2);
      keys_down <= 8'h00;
      wr(EN, 8'h08);
      s_axi_wstrb <= 4'hE;
      wr(EN, 8'hFF);
      s_axi_wstrb <= 4'hF;
      rd_chk("strobe off", EN, 32'h00000008);
      outs(8'h08, 1'b0, 1'b0, 1'b0);
      wr(GE, 8'h01);
      outs(8'h08, 1'b1, 1'b0, 1'b0);
      wr(EN, 8'h04);
      outs(8'h04, 1'b0, 1'b0, 1'b0);
      wr(EN, 8'h08);
      wr(FL, 8'h00);
      keys_down <= 8'h04;
      step(1);
      outs(8'h08, 1'b0, 1'b0, 1'b0);
      keys_down <= 8'h08;
      step(1);
      outs(8'h08, 1'b1, 1'b1, 1'b0);
      keys_down <= 8'h00;
      wr(FL, 8'h00);
      wr(CL, 8'h03);
      rd_chk("status cleared", ST, 32'h00000000);
      wr(EE, 8'h03);
      keys_down <= 8'h08;
      step(2);
      keys_down <= 8'h00;
      rd_chk("status", ST, 32'h00000003);
      outs(8'h08, 1'b1, 1'b0, 1'b1);
      wr(EE, 8'h00);
      outs(8'h08, 1'b1, 1'b0, 1'b0);
      wr(CL, 8'h01);
      rd_chk("status partly cleared", ST, 32'h00000002);
      wr(EE, 8'h03);
      outs(8'h08, 1'b1, 1'b0, 1'b1);
      wr(CL, 8'h02);
      outs(8'h08, 1'b1, 1'b0, 1'b0);
      end_sim();
   end
endmodule
